// ### mtc_params.svh
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH
// root pointer field positions (upper word bits 63..32, lower word 31..0)
`define MTC_RP_LU_BIT      63
`define MTC_RP_LIMIT_HI    62
`define MTC_RP_LIMIT_LO    48
`define MTC_RP_DT_HI       33
`define MTC_RP_DT_LO       32
`define MTC_RP_BASE_HI     31
`define MTC_RP_BASE_LO     4
// limit words that switch limiting off
`define MTC_NOLIM_UPPER    16'h7FFF
`define MTC_NOLIM_LOWER    16'h8000
// translation control field positions
`define MTC_TC_EN_BIT      31
`define MTC_TC_SRE_BIT     25
`define MTC_TC_FCL_BIT     24
`define MTC_TC_PS_HI       23
`define MTC_TC_PS_LO       20
`define MTC_TC_IS_HI       19
`define MTC_TC_IS_LO       16
`define MTC_TC_TI_HI       15
`define MTC_TC_TI_LO       0
`define MTC_TC_IMPL_MASK   32'h83FFFFFF
// consistency total and smallest legal page size code
`define MTC_ADDR_BITS      6'h20
`define MTC_PS_MIN         4'h8
// reset values
`define MTC_TC_RESET       32'h00000000
`define MTC_RP_RESET       64'h0000000000000000
// descriptor kinds
`define MTC_DT_INVALID     2'h0
`define MTC_DT_PAGE        2'h1
`define MTC_DT_SHORT       2'h2
`define MTC_DT_LONG        2'h3
`endif

// ### mtc_pkg.sv
package mtc_pkg;
  // register selected by a move-translation-register operation
  typedef enum logic [1:0] {
    MTC_SEL_USER_ROOT,
    MTC_SEL_SUPER_ROOT,
    MTC_SEL_CONTROL,
    MTC_SEL_NONE
  } mtc_sel_t;

  // one register access from the core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        flush;
    mtc_sel_t    sel;
    logic [63:0] data;
  } mtc_req_t;

  // one translation query from the core
  typedef struct packed {
    logic        valid;
    logic        priv_super;  // access made at supervisor level
    logic [2:0]  fc;
    logic [31:0] addr;
    logic [14:0] next_index;
    logic        level_is_fc;
  } mtc_acc_t;

  // answer to a translation query
  typedef struct packed {
    logic        valid;
    logic        use_super;
    logic        fc_first;
    logic        direct;
    logic        walk;
    logic [31:0] phys;
    logic [27:0] table_base;
    logic [17:0] desc_offset;
    logic        limit_fault;
  } mtc_ans_t;
endpackage

// ### mtc_config.sv
`timescale 1ns/1ps
`include "mtc_params.svh"
// Contract
// - limit is lower bound when direction set
// - 7FFF or 8000 word disables limiting
// - function code level never limit checked
// - invalid root descriptor raises configuration exception
// - page root maps by adding base
// - page root always limit checked
// - short root scales index by four
// - long root scales index by eight
// - base from bits 31-4, zero allowed
// - root bits 3-0 ignored, others zero
// - unimplemented control fields read zero
// - control write optionally flushes cache
// - enabled control write checks width sum
// - on exception store value, clear enable
// - enable clears on reset, else passthrough
// - operations work regardless of enable
// - supervisor root select chooses root
// - function code lookup indexes first table
// - function code lookup ignores root limit
// - page size codes 8-15, others except
// - initial shift skips high address bits
// - four index width fields, highest first
// - zero index width ends the search
// - root pointers are 64-bit registers
module mtc_config
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire mtc_pkg::mtc_req_t i_req,
  input  wire mtc_pkg::mtc_acc_t i_acc,
  output logic [63:0]           o_rd_data,
  output logic                  o_rd_valid,
  output logic                  o_cfg_exc,
  output logic                  o_flush,
  output logic                  o_xlate_en,
  output logic [2:0]            o_levels,
  output logic [3:0]            o_page_code,
  output logic [3:0]            o_init_shift,
  output mtc_pkg::mtc_ans_t     o_ans
);
  import mtc_pkg::*;

  // stored register fields
  logic        usr_lu_q;          // user root limit direction
  logic [14:0] usr_lim_q;         // user root limit
  logic [1:0]  usr_dt_q;          // user root descriptor_kind
  logic [27:0] usr_base_q;        // user root table base (bits 31-4)
  logic        sup_lu_q;          // supervisor root limit direction
  logic [14:0] sup_lim_q;         // supervisor root limit
  logic [1:0]  sup_dt_q;          // supervisor root descriptor_kind
  logic [27:0] sup_base_q;        // supervisor root table base
  logic [31:0] tc_q;              // translation_control, implemented bits only

  // decoded control fields
  logic        tc_en;
  logic        tc_sre;
  logic        tc_fcl;
  logic [3:0]  tc_ps;
  logic [3:0]  tc_is;
  logic [15:0] tc_ti;

  assign tc_en  = tc_q[`MTC_TC_EN_BIT];
  assign tc_sre = tc_q[`MTC_TC_SRE_BIT];
  assign tc_fcl = tc_q[`MTC_TC_FCL_BIT];
  assign tc_ps  = tc_q[`MTC_TC_PS_HI:`MTC_TC_PS_LO];
  assign tc_is  = tc_q[`MTC_TC_IS_HI:`MTC_TC_IS_LO];
  assign tc_ti  = tc_q[`MTC_TC_TI_HI:`MTC_TC_TI_LO];

  // sum of index widths up to the first zero field, highest level first
  function automatic logic [5:0] ti_sum(input logic [15:0] ti);
    logic [5:0] s;
    logic       stop;
    s    = 6'h00;
    stop = 1'b0;
    for (int k = 3; k >= 0; k--)
    begin
      if (ti[k*4 +: 4] == 4'h0)
        stop = 1'b1;
      else if (!stop)
        s = s + {2'h0, ti[k*4 +: 4]};
    end
    return s;
  endfunction

  // number of levels before the first zero width field
  function automatic logic [2:0] ti_levels(input logic [15:0] ti);
    logic [2:0] n;
    logic       stop;
    n    = 3'h0;
    stop = 1'b0;
    for (int k = 3; k >= 0; k--)
    begin
      if (ti[k*4 +: 4] == 4'h0)
        stop = 1'b1;
      else if (!stop)
        n = n + 3'h1;
    end
    return n;
  endfunction

  // write decode
  logic        wr_usr;
  logic        wr_sup;
  logic        wr_tc;
  logic [31:0] wr_tc_val;
  logic [5:0]  wr_total;
  logic        ps_bad;
  logic        sum_bad;
  logic        root_bad;
  logic        exc_now;

  assign wr_usr    = i_req.wr && (i_req.sel == MTC_SEL_USER_ROOT);
  assign wr_sup    = i_req.wr && (i_req.sel == MTC_SEL_SUPER_ROOT);
  assign wr_tc     = i_req.wr && (i_req.sel == MTC_SEL_CONTROL);
  // unimplemented fields dropped on the way in
  assign wr_tc_val = i_req.data[31:0] & `MTC_TC_IMPL_MASK;
  // widths up to first zero, plus page size and initial shift
  assign wr_total  = ti_sum(wr_tc_val[`MTC_TC_TI_HI:`MTC_TC_TI_LO])
                   + {2'h0, wr_tc_val[`MTC_TC_PS_HI:`MTC_TC_PS_LO]}
                   + {2'h0, wr_tc_val[`MTC_TC_IS_HI:`MTC_TC_IS_LO]};
  // page size codes below 1000 are reserved, on any control load
  assign ps_bad    = wr_tc_val[`MTC_TC_PS_HI:`MTC_TC_PS_LO] < `MTC_PS_MIN;
  // the check only runs when the written value enables translation
  assign sum_bad   = wr_tc_val[`MTC_TC_EN_BIT] && (wr_total != `MTC_ADDR_BITS);
  // invalid kind is forbidden at root level
  assign root_bad  = (wr_usr || wr_sup)
                     && (i_req.data[`MTC_RP_DT_HI:`MTC_RP_DT_LO] == `MTC_DT_INVALID);
  assign exc_now   = root_bad || (wr_tc && (ps_bad || sum_bad));

  // user root pointer: bits 3-0 and other unused bits are not kept
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      usr_lu_q   <= 1'b0;
      usr_lim_q  <= 15'h0000;
      usr_dt_q   <= `MTC_DT_INVALID;
      usr_base_q <= 28'h0000000;
    end
    else if (wr_usr)
    begin
      // stored even when it raises an exception, so software can read it back
      usr_lu_q   <= i_req.data[`MTC_RP_LU_BIT];
      usr_lim_q  <= i_req.data[`MTC_RP_LIMIT_HI:`MTC_RP_LIMIT_LO];
      usr_dt_q   <= i_req.data[`MTC_RP_DT_HI:`MTC_RP_DT_LO];
      usr_base_q <= i_req.data[`MTC_RP_BASE_HI:`MTC_RP_BASE_LO];
    end
  end

  // supervisor root pointer
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sup_lu_q   <= 1'b0;
      sup_lim_q  <= 15'h0000;
      sup_dt_q   <= `MTC_DT_INVALID;
      sup_base_q <= 28'h0000000;
    end
    else if (wr_sup)
    begin
      sup_lu_q   <= i_req.data[`MTC_RP_LU_BIT];
      sup_lim_q  <= i_req.data[`MTC_RP_LIMIT_HI:`MTC_RP_LIMIT_LO];
      sup_dt_q   <= i_req.data[`MTC_RP_DT_HI:`MTC_RP_DT_LO];
      sup_base_q <= i_req.data[`MTC_RP_BASE_HI:`MTC_RP_BASE_LO];
    end
  end

  // translation control: enable clears on reset and on a failed check
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      tc_q <= `MTC_TC_RESET;
    else if (wr_tc)
    begin
      // accepted whatever the current enable says
      if (ps_bad || sum_bad)
        tc_q <= wr_tc_val & ~(32'h1 << `MTC_TC_EN_BIT);
      else
        tc_q <= wr_tc_val;
    end
  end

  // exception and flush pulses, one cycle after the write
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cfg_exc <= 1'b0;
      o_flush   <= 1'b0;
    end
    else
    begin
      o_cfg_exc <= exc_now;
      // any register load may flush, as the instruction selects
      o_flush   <= i_req.wr && i_req.flush && (i_req.sel != MTC_SEL_NONE);
    end
  end

  // decoded configuration outputs follow the stored control register
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_xlate_en   <= 1'b0;
      o_levels     <= 3'h0;
      o_page_code  <= 4'h0;
      o_init_shift <= 4'h0;
    end
    else
    begin
      o_xlate_en   <= tc_en;
      o_levels     <= ti_levels(tc_ti);
      o_page_code  <= tc_ps;
      o_init_shift <= tc_is;
    end
  end

  // register read back; unused bits read zero
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rd_data  <= `MTC_RP_RESET;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_req.rd;
      if (i_req.rd)
      begin
        case (i_req.sel)
          MTC_SEL_USER_ROOT:
            o_rd_data <= {usr_lu_q, usr_lim_q, 14'h0000, usr_dt_q, usr_base_q, 4'h0};
          MTC_SEL_SUPER_ROOT:
            o_rd_data <= {sup_lu_q, sup_lim_q, 14'h0000, sup_dt_q, sup_base_q, 4'h0};
          MTC_SEL_CONTROL:
            o_rd_data <= {32'h00000000, tc_q};
          default:
            o_rd_data <= 64'h0000000000000000;
        endcase
      end
    end
  end

  // root selection for the access
  logic        q_super;
  logic        q_lu;
  logic [14:0] q_lim;
  logic [1:0]  q_dt;
  logic [27:0] q_base;
  logic        q_lim_on;
  logic        q_fault;
  logic [31:0] q_direct_pa;

  // supervisor root only when selected and the access is supervisor
  assign q_super = tc_sre && i_acc.priv_super;
  assign q_lu    = q_super ? sup_lu_q   : usr_lu_q;
  assign q_lim   = q_super ? sup_lim_q  : usr_lim_q;
  assign q_dt    = q_super ? sup_dt_q   : usr_dt_q;
  assign q_base  = q_super ? sup_base_q : usr_base_q;
  // page roots always check; lookup by function code drops the limit;
  // the function code level itself is never limited
  assign q_lim_on = !i_acc.level_is_fc
                    && (!tc_fcl || (q_dt == `MTC_DT_PAGE));
  // 7FFF and 8000 words pass every index through these compares
  assign q_fault  = q_lim_on && (q_lu ? (i_acc.next_index < q_lim)
                                      : (i_acc.next_index > q_lim));
  assign q_direct_pa = i_acc.addr + {q_base, 4'h0};

  // translation answer, one cycle after the query
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_ans <= '0;
    else
    begin
      o_ans.valid       <= i_acc.valid;
      o_ans.use_super   <= q_super;
      o_ans.fc_first    <= tc_fcl;
      o_ans.table_base  <= q_base;
      o_ans.limit_fault <= i_acc.valid && tc_en && q_fault;
      o_ans.desc_offset <= (q_dt == `MTC_DT_LONG)
                           ? {i_acc.next_index, 3'h0}
                           : {1'b0, i_acc.next_index, 2'h0};
      if (!tc_en)
      begin
        // disabled: logical address is the physical address
        o_ans.phys   <= i_acc.addr;
        o_ans.direct <= 1'b0;
        o_ans.walk   <= 1'b0;
      end
      else if (q_dt == `MTC_DT_PAGE)
      begin
        o_ans.phys   <= q_direct_pa;
        o_ans.direct <= 1'b1;
        o_ans.walk   <= 1'b0;
      end
      else
      begin
        o_ans.phys   <= i_acc.addr;
        o_ans.direct <= 1'b0;
        o_ans.walk   <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  root_invalid_exc_a: assert property (
    (i_req.wr && i_req.sel != MTC_SEL_CONTROL && i_req.sel != MTC_SEL_NONE
     && i_req.data[`MTC_RP_DT_HI:`MTC_RP_DT_LO] == `MTC_DT_INVALID) |=> o_cfg_exc)
    else $error("invalid root load gave no exception");

  tc_sum_check_a: assert property (
    (wr_tc && wr_tc_val[`MTC_TC_EN_BIT] && wr_total != `MTC_ADDR_BITS)
    |=> (o_cfg_exc && !tc_q[`MTC_TC_EN_BIT]))
    else $error("bad width sum accepted");

  tc_exc_store_a: assert property (
    (wr_tc && exc_now) |=> (tc_q == ($past(i_req.data[31:0]) & `MTC_TC_IMPL_MASK
                                     & ~(32'h1 << `MTC_TC_EN_BIT))))
    else $error("control value not stored on exception");

  tc_good_keep_a: assert property (
    (wr_tc && !exc_now) |=> ##1 (o_xlate_en == $past(wr_tc_val[31], 2)))
    else $error("good control write did not set enable");

  page_size_bad_a: assert property (
    (wr_tc && i_req.data[`MTC_TC_PS_HI:`MTC_TC_PS_LO] < `MTC_PS_MIN) |=> o_cfg_exc)
    else $error("reserved page size accepted");

  exc_pulse_one_a: assert property (
    o_cfg_exc |-> $past(i_req.wr))
    else $error("exception without a write");

  passthru_off_a: assert property (
    (i_acc.valid && !tc_en) |=> (o_ans.phys == $past(i_acc.addr) && !o_ans.walk))
    else $error("disabled translation altered address");

  fc_level_nolim_a: assert property (
    (i_acc.valid && i_acc.level_is_fc) |=> !o_ans.limit_fault)
    else $error("function code level was limited");

  nolimit_word_a: assert property (
    (i_acc.valid && ({q_lu, q_lim} == `MTC_NOLIM_UPPER || {q_lu, q_lim} == `MTC_NOLIM_LOWER))
    |=> !o_ans.limit_fault)
    else $error("disabled limit still faulted");

  root_select_a: assert property (
    (i_acc.valid && !tc_sre) |=> !o_ans.use_super)
    else $error("supervisor root used while not selected");

  long_scale_a: assert property (
    (i_acc.valid && q_dt == `MTC_DT_LONG) |=> (o_ans.desc_offset[2:0] == 3'h0))
    else $error("long root index not scaled by eight");

  flush_req_a: assert property (
    (wr_tc && i_req.flush) |=> o_flush)
    else $error("flush request lost");

  cov_exc_c:    cover property (wr_tc && sum_bad ##1 o_cfg_exc);
  cov_direct_c: cover property (i_acc.valid && tc_en && q_dt == `MTC_DT_PAGE ##1 o_ans.direct);
  cov_fault_c:  cover property (i_acc.valid ##1 o_ans.limit_fault);
  cov_super_c:  cover property (i_acc.valid && q_super ##1 o_ans.use_super);
endmodule // mtc_config

// ### mtc_core_model.sv
`timescale 1ns/1ps
module mtc_core_model
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_keep_rules,
  output mtc_pkg::mtc_req_t o_req
);
  import mtc_pkg::*;

  // core stays quiet until the bench asks for an access
  initial o_req = '0;

  // one access: launched after an edge, held through the taking edge
  task automatic access(input logic wr, input logic rd, input logic fl,
                        input mtc_sel_t sel, input logic [63:0] d);
    logic [63:0] v; // data as the core really drives it
    v = d;
    // a careless core may leave spare bits set; only when told to
    if (i_keep_rules && sel == MTC_SEL_CONTROL)
      v = v & 64'h0000000083FFFFFF;
    else if (i_keep_rules)
      v = v & 64'hFFFF0003FFFFFFFF;
    @(posedge i_clk_sys);
    #1;
    o_req = '{wr: wr, rd: rd, flush: fl, sel: sel, data: v};
    @(posedge i_clk_sys);
    #1;
    // released bus shows junk, not the last value
    o_req = '{wr: 1'b0, rd: 1'b0, flush: 1'b0, sel: MTC_SEL_NONE, data: ~v};
  endtask
endmodule // mtc_core_model

// ### mtc_config_bench.sv
`timescale 1ns/1ps
module mtc_config_bench;
  import mtc_pkg::*;
  logic        clk;        // system clock
  logic        rst_n;      // async reset, low active
  logic        keep;       // core keeps software rules
  mtc_req_t    req;        // access from core model
  mtc_acc_t    acc;        // translation query
  logic [63:0] rd_data;
  logic        rd_valid;
  logic        cfg_exc;
  logic        flush;
  logic        xlate_en;
  logic [2:0]  levels;
  logic [3:0]  page_code;
  logic [3:0]  init_shift;
  mtc_ans_t    ans;
  logic [31:0] tc_m;       // expected control contents
  logic [63:0] rp_m [2];   // expected user and supervisor roots
  int          fails;
  int          n_checks;
  // legal layouts: 12 + 0 + 10 + 10 = 32, differing in root, fc and enable options
  logic [31:0] tcs [5] = '{32'h80C0AA00, 32'h81C0AA00, 32'h82C0AA00, 32'h83C0AA00,
                           32'h00C0AA00};

  // clock at 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  mtc_config dut
  (
    .i_clk_sys    (clk),
    .i_reset_n    (rst_n),
    .i_req        (req),
    .i_acc        (acc),
    .o_rd_data    (rd_data),
    .o_rd_valid   (rd_valid),
    .o_cfg_exc    (cfg_exc),
    .o_flush      (flush),
    .o_xlate_en   (xlate_en),
    .o_levels     (levels),
    .o_page_code  (page_code),
    .o_init_shift (init_shift),
    .o_ans        (ans)
  );

  mtc_core_model core
  (
    .i_clk_sys    (clk),
    .i_keep_rules (keep),
    .o_req        (req)
  );

  // index levels ahead of the first zero width
  function automatic int lv(logic [31:0] v);
    int n;
    n = 0;
    while (n < 4 && v[(3 - n) * 4 +: 4] != 4'h0)
      n++;
    return n;
  endfunction

  // control value that must raise the configuration exception
  function automatic logic tc_bad(logic [31:0] v);
    int s;
    s = v[23:20] + v[19:16];
    for (int n = 0; n < lv(v); n++)
      s += v[(3 - n) * 4 +: 4];
    return (v[23:20] < 4'h8) || (v[31] && s != 32);
  endfunction

  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      fails++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic get(input mtc_sel_t sel, input logic [63:0] e);
    core.access(1'b0, 1'b1, 1'b0, sel, 64'h0);
    cmp("read valid", 1'b1, rd_valid);
    cmp("read data", e, rd_data);
  endtask

  // write, then check pulse, derived outputs and read back
  task automatic put(input mtc_sel_t sel, input logic [63:0] d, input logic fl);
    logic [63:0] v;
    logic        x;
    if (sel == MTC_SEL_CONTROL)
    begin
      v = {32'h0, d[31:0] & 32'h83FFFFFF};
      x = tc_bad(v[31:0]);
      if (x)
        v[31] = 1'b0;
    end
    else
    begin
      v = d & 64'hFFFF0003FFFFFFF0;
      x = (d[33:32] == 2'h0);
    end
    core.access(1'b1, 1'b0, fl, sel, d);
    cmp("exception", x, cfg_exc);
    cmp("flush", fl, flush);
    @(posedge clk);
    #1;
    cmp("exception pulse", 1'b0, cfg_exc);
    if (sel == MTC_SEL_CONTROL)
    begin
      tc_m = v[31:0];
      cmp("enable", v[31], xlate_en);
      cmp("levels", lv(v[31:0]), levels);
      cmp("page size", v[23:20], page_code);
      cmp("shift", v[19:16], init_shift);
    end
    else
      rp_m[sel == MTC_SEL_SUPER_ROOT] = v;
    get(sel, v);
  endtask

  // one translation query against the expected register state
  task automatic q(input logic s, input logic [31:0] a, input logic [14:0] ix, input logic f);
    logic [63:0] rp;
    logic        us;
    logic        en;
    logic [31:0] ph;
    logic        lf;
    us = tc_m[25] & s;
    rp = rp_m[us];
    en = tc_m[31];
    ph = (en && rp[33:32] == 2'h1) ? a + {rp[31:4], 4'h0} : a;
    lf = en && !f && (!tc_m[24] || rp[33:32] == 2'h1) &&
         (rp[63] ? ix < rp[62:48] : ix > rp[62:48]);
    @(posedge clk);
    #1;
    acc = '{valid: 1'b1, priv_super: s, fc: 3'($urandom), addr: a,
            next_index: ix, level_is_fc: f};
    @(posedge clk);
    #1;
    acc = '{valid: 1'b0, priv_super: ~s, fc: 3'h0, addr: ~a,
            next_index: ~ix, level_is_fc: ~f};
    cmp("answer valid", 1'b1, ans.valid);
    cmp("phys", ph, ans.phys);
    cmp("limit", lf, ans.limit_fault);
    cmp("direct", en && rp[33:32] == 2'h1, ans.direct);
    cmp("walk", en && rp[33:32] != 2'h1, ans.walk);
    if (en)
    begin
      cmp("root select", us, ans.use_super);
      cmp("fc first", tc_m[24], ans.fc_first);
      cmp("base", rp[31:4], ans.table_base);
      cmp("offset", rp[33:32] == 2'h3 ? ix * 8 : ix * 4, ans.desc_offset);
    end
  endtask

  initial
  begin
    logic [15:0] lw; // direction bit and limit of a root
    void'($urandom(19));
    rst_n = 1'b0;
    keep = 1'b1;
    acc = '0;
    fails = 0;
    n_checks = 0;
    tc_m = '0;
    rp_m = '{default: '0};
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmp("enable at reset", 1'b0, xlate_en);
    get(MTC_SEL_USER_ROOT, 64'h0);
    get(MTC_SEL_SUPER_ROOT, 64'h0);
    get(MTC_SEL_CONTROL, 64'h0);
    $display("test reset done");
    put(MTC_SEL_CONTROL, 64'h80C0AA00, 1'b1);
    put(MTC_SEL_CONTROL, 64'h80C0AA00, 1'b0);
    put(MTC_SEL_CONTROL, 64'h80F84440, 1'b0);
    for (int p = 0; p < 16; p++)
      put(MTC_SEL_CONTROL, {40'h0, p[3:0], 20'h0}, 1'b0);
    for (int k = 0; k < 4; k++)
      put(MTC_SEL_SUPER_ROOT, {30'h1FFFC000, k[1:0], 32'h1234567F}, 1'b0);
    keep = 1'b0;
    put(MTC_SEL_CONTROL, 64'hFFFFFFFFFFFFFFFF, 1'b0);
    put(MTC_SEL_USER_ROOT, 64'hFFFFFFFFFFFFFFFF, 1'b1);
    keep = 1'b1;
    $display("test corners done");
    repeat (60)
    begin
      put(MTC_SEL_CONTROL, {32'h0, tcs[$urandom_range(0, 4)]}, 1'($urandom));
      for (int k = 0; k < 2; k++)
      begin
        lw = $urandom_range(0, 1) ? 16'($urandom) & 16'h80FF :
             ($urandom_range(0, 1) ? 16'h7FFF : 16'h8000);
        put(k ? MTC_SEL_SUPER_ROOT : MTC_SEL_USER_ROOT,
            {lw, 14'h0, 2'($urandom_range(1, 3)), 32'($urandom)}, 1'b0);
      end
      repeat (4)
        // skipped high address bits are passed whole, as software keeps them defined
        q(1'($urandom), $urandom, 15'($urandom_range(0, 511)),
          $urandom_range(0, 3) == 0);
    end
    $display("test random done");
    complete_run();
  end

  // hang guard, far beyond the some 1500 cycles the tests need
  initial
  begin
    #80000;
    fails++;
    $display("CHECK FAILED watchdog expected done seen hang");
    complete_run();
  end
endmodule // mtc_config_bench
